// ==== core/pdc_regs.vh ====
`ifndef PDC_REGS_VH
`define PDC_REGS_VH

// Register indices; byte address is four times the index.
`define PDC_IDX_AGC_BW          12'h116
`define PDC_IDX_BAD_THR         12'h121
`define PDC_IDX_TIM_THR         12'h122
`define PDC_IDX_LNK_THR         12'h123
`define PDC_IDX_TRAIN_TMR       12'h126
`define PDC_IDX_GAIN_LIM        12'h129
`define PDC_IDX_GAIN_RETRAIN    12'h130
`define PDC_IDX_ALINK_DIAG      12'h155
`define PDC_IDX_REFL_CTRL       12'h170
`define PDC_IDX_REFL_PULSE      12'h171
`define PDC_IDX_REFL_LISTEN     12'h173
`define PDC_IDX_REFL_SHORT      12'h177
`define PDC_IDX_IRQ_STATUS      12'h1f0
`define PDC_IDX_IRQ_MASK        12'h1f1

// Reset values.
`define PDC_RST_AGC_BW          16'h014a
`define PDC_RST_BAD_THR         15'h199a
`define PDC_RST_TIM_THR         15'h1027
`define PDC_RST_LNK_THR         15'h051c
`define PDC_RST_TRAIN_TMR       16'h461b
`define PDC_RST_GAIN_LIM        16'h000f
`define PDC_RST_GAIN_RETRAIN    16'h0001
`define PDC_RST_ALINK_LOW       4'h1
`define PDC_RST_REFL_CTRL       16'h0e52
`define PDC_RST_REFL_PULSE      16'hc85c
`define PDC_RST_REFL_LISTEN     16'hff1e
`define PDC_RST_REFL_SHORT      16'h189b

// Field positions.
`define PDC_BIT_ALINK_START     15
`define PDC_BIT_ALINK_BUSY      12
`define PDC_BIT_CROSS_DIS       14
`define PDC_BIT_TX_BYPASS       13
`define PDC_BIT_RX_BYPASS       12
`define PDC_BIT_RETRAIN_DIS     11
`define PDC_AVG_RESERVED        3'h7

// Interrupt status bits.
`define PDC_IRQ_ALINK_DONE      0
`define PDC_IRQ_RECOVERY        1
`define PDC_IRQ_LINKUP          2

`endif

// ==== core/pdc_diag_regs.v ====
// Design decision made here: the plain strobed port.
`include "pdc_regs.vh"

module pdc_diag_regs
(
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    input  wire        clk_en,
    // Register port
    input  wire [11:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Receive DSP
    input  wire        dsp_mse_valid,
    input  wire [14:0] dsp_mse,
    input  wire        dsp_gain_retrain_req,
    input  wire [3:0]  dsp_gain_req,
    output reg         dsp_recovery,
    output reg         dsp_timing_locked,
    output reg         dsp_linkup_ok,
    output reg         dsp_gain_retrain,
    output reg  [3:0]  dsp_gain_index,
    output wire [2:0]  dsp_state_timer,
    output wire [5:0]  dsp_timing_timer,
    output wire [2:0]  dsp_gain_timer_a,
    output wire [2:0]  dsp_gain_timer_b,
    // Active-link cable test engine
    output reg         alink_start,
    input  wire        alink_done,
    input  wire [7:0]  alink_sum,
    // Reflectometry engine
    output wire        refl_cross_en,
    output wire        refl_tx_run,
    output wire        refl_rx_run,
    output wire [6:0]  refl_avg_cycles,
    output wire [3:0]  refl_pulse_level,
    output wire [7:0]  refl_listen_len,
    // Interrupt
    output wire        irq
);

    reg [15:0] agc_bw_ff;
    reg [14:0] bad_thr_ff;
    reg [14:0] tim_thr_ff;
    reg [14:0] lnk_thr_ff;
    reg [15:0] train_tmr_ff;
    reg [15:0] gain_lim_ff;
    reg [15:0] retrain_ff;
    reg        alink_busy_ff;
    reg [7:0]  alink_sum_ff;
    reg [3:0]  alink_low_ff;
    reg [15:0] refl_ctrl_ff;
    reg [15:0] refl_pulse_ff;
    reg [15:0] refl_listen_ff;
    reg [15:0] refl_short_ff;
    reg [2:0]  irq_stat_ff;
    reg [2:0]  irq_mask_ff;
    reg        done_s1_ff;
    reg        done_s2_ff;
    reg        done_d_ff;
    reg        linkup_d_ff;
    reg        recov_d_ff;
    reg [15:0] nxt_rdata;
    reg [3:0]  nxt_gain;
    wire       done_rise;
    wire [2:0] irq_evt;
    wire [3:0] gain_max;
    wire [3:0] gain_min;

    // One-hot select for a register index.
    function hit;
        input [11:0] addr;
        input [11:0] idx;
        begin
            hit = (addr == idx);
        end
    endfunction

    wire wr_alink = reg_wr && hit(reg_addr, `PDC_IDX_ALINK_DIAG);

    // The engine's done comes from the analog side, so it is synchronised.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_d_ff  <= 1'b0;
        end
        else if (clk_en)
        begin
            done_s1_ff <= alink_done;
            done_s2_ff <= done_s1_ff;
            done_d_ff  <= done_s2_ff;
        end
    end

    assign done_rise = done_s2_ff && !done_d_ff;

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            agc_bw_ff      <= `PDC_RST_AGC_BW;
            bad_thr_ff     <= `PDC_RST_BAD_THR;
            tim_thr_ff     <= `PDC_RST_TIM_THR;
            lnk_thr_ff     <= `PDC_RST_LNK_THR;
            train_tmr_ff   <= `PDC_RST_TRAIN_TMR;
            gain_lim_ff    <= `PDC_RST_GAIN_LIM;
            retrain_ff     <= `PDC_RST_GAIN_RETRAIN;
            alink_low_ff   <= `PDC_RST_ALINK_LOW;
            refl_ctrl_ff   <= `PDC_RST_REFL_CTRL;
            refl_pulse_ff  <= `PDC_RST_REFL_PULSE;
            refl_listen_ff <= `PDC_RST_REFL_LISTEN;
            refl_short_ff  <= `PDC_RST_REFL_SHORT;
            irq_mask_ff    <= 3'h0;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `PDC_IDX_AGC_BW:       agc_bw_ff      <= reg_wdata;
                `PDC_IDX_BAD_THR:      bad_thr_ff     <= reg_wdata[14:0];
                `PDC_IDX_TIM_THR:      tim_thr_ff     <= reg_wdata[14:0];
                `PDC_IDX_LNK_THR:      lnk_thr_ff     <= reg_wdata[14:0];
                `PDC_IDX_TRAIN_TMR:    train_tmr_ff   <= reg_wdata;
                `PDC_IDX_GAIN_LIM:     gain_lim_ff    <= reg_wdata;
                `PDC_IDX_GAIN_RETRAIN: retrain_ff     <= reg_wdata;
                `PDC_IDX_ALINK_DIAG:   alink_low_ff   <= reg_wdata[3:0];
                `PDC_IDX_REFL_CTRL:    refl_ctrl_ff   <= {1'b0, reg_wdata[14:0]};
                `PDC_IDX_REFL_PULSE:   refl_pulse_ff  <= reg_wdata;
                `PDC_IDX_REFL_LISTEN:  refl_listen_ff <= reg_wdata;
                `PDC_IDX_REFL_SHORT:   refl_short_ff  <= reg_wdata;
                `PDC_IDX_IRQ_MASK:     irq_mask_ff    <= reg_wdata[2:0];
                default:               irq_mask_ff    <= irq_mask_ff;
            endcase
        end
    end

    // Start is a one-cycle pulse; the bit never stores, so it reads zero.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            alink_start   <= 1'b0;
            alink_busy_ff <= 1'b0;
            alink_sum_ff  <= 8'h00;
        end
        else if (clk_en)
        begin
            alink_start <= wr_alink && reg_wdata[`PDC_BIT_ALINK_START] && !alink_busy_ff;
            if (wr_alink && reg_wdata[`PDC_BIT_ALINK_START])
                alink_busy_ff <= 1'b1;
            else if (done_rise && alink_busy_ff)
            begin
                alink_busy_ff <= 1'b0;
                alink_sum_ff  <= alink_sum;
            end
        end
    end

    // Error-level comparisons; one sample per valid strobe.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dsp_recovery      <= 1'b0;
            dsp_timing_locked <= 1'b0;
            dsp_linkup_ok     <= 1'b0;
        end
        else if (clk_en && dsp_mse_valid)
        begin
            dsp_recovery      <= (dsp_mse > bad_thr_ff);
            dsp_timing_locked <= (dsp_mse < tim_thr_ff);
            dsp_linkup_ok     <= (dsp_mse < lnk_thr_ff);
        end
    end

    assign gain_max = gain_lim_ff[7:4];
    assign gain_min = gain_lim_ff[3:0];

    // Clamp to the limits; if they cross, the upper limit takes precedence.
    always @*
    begin
        nxt_gain = dsp_gain_req;
        if (dsp_gain_req < gain_min)
            nxt_gain = gain_min;
        if (nxt_gain > gain_max)
            nxt_gain = gain_max;
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dsp_gain_index   <= 4'h0;
            dsp_gain_retrain <= 1'b0;
        end
        else if (clk_en)
        begin
            dsp_gain_index   <= nxt_gain;
            dsp_gain_retrain <= dsp_gain_retrain_req && !retrain_ff[`PDC_BIT_RETRAIN_DIS];
        end
    end

    assign dsp_state_timer  = train_tmr_ff[14:12];
    assign dsp_timing_timer = train_tmr_ff[11:6];
    assign dsp_gain_timer_a = train_tmr_ff[5:3];
    assign dsp_gain_timer_b = train_tmr_ff[2:0];

    assign refl_cross_en = !refl_ctrl_ff[`PDC_BIT_CROSS_DIS];
    assign refl_tx_run   = !refl_ctrl_ff[`PDC_BIT_TX_BYPASS];
    assign refl_rx_run   = !refl_ctrl_ff[`PDC_BIT_RX_BYPASS];
    // The reserved code is held at the largest legal count.
    assign refl_avg_cycles = (refl_ctrl_ff[10:8] == `PDC_AVG_RESERVED) ? 7'h40
                           : (7'h01 << refl_ctrl_ff[10:8]);
    assign refl_pulse_level = refl_pulse_ff[3:0];
    assign refl_listen_len  = refl_listen_ff[15:8];

    // Sticky events: completion, recovery entry, link-up permitted.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            recov_d_ff  <= 1'b0;
            linkup_d_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            recov_d_ff  <= dsp_recovery;
            linkup_d_ff <= dsp_linkup_ok;
        end
    end

    assign irq_evt = {dsp_linkup_ok && !linkup_d_ff,
                      dsp_recovery && !recov_d_ff,
                      done_rise && alink_busy_ff};

    // Set wins over a write-one clear in the same cycle.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            irq_stat_ff <= 3'h0;
        else if (clk_en)
        begin
            if (reg_wr && hit(reg_addr, `PDC_IDX_IRQ_STATUS))
                irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | irq_evt;
            else
                irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    always @*
    begin
        case (reg_addr)
            `PDC_IDX_AGC_BW:       nxt_rdata = agc_bw_ff;
            `PDC_IDX_BAD_THR:      nxt_rdata = {1'b0, bad_thr_ff};
            `PDC_IDX_TIM_THR:      nxt_rdata = {1'b0, tim_thr_ff};
            `PDC_IDX_LNK_THR:      nxt_rdata = {1'b0, lnk_thr_ff};
            `PDC_IDX_TRAIN_TMR:    nxt_rdata = train_tmr_ff;
            `PDC_IDX_GAIN_LIM:     nxt_rdata = gain_lim_ff;
            `PDC_IDX_GAIN_RETRAIN: nxt_rdata = retrain_ff;
            `PDC_IDX_ALINK_DIAG:   nxt_rdata = {3'h0, alink_busy_ff, alink_sum_ff, alink_low_ff};
            `PDC_IDX_REFL_CTRL:    nxt_rdata = refl_ctrl_ff;
            `PDC_IDX_REFL_PULSE:   nxt_rdata = refl_pulse_ff;
            `PDC_IDX_REFL_LISTEN:  nxt_rdata = refl_listen_ff;
            `PDC_IDX_REFL_SHORT:   nxt_rdata = refl_short_ff;
            `PDC_IDX_IRQ_STATUS:   nxt_rdata = {13'h0000, irq_stat_ff};
            `PDC_IDX_IRQ_MASK:     nxt_rdata = {13'h0000, irq_mask_ff};
            default:               nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 16'h0000;
        else if (clk_en)
            reg_rdata <= reg_rd ? nxt_rdata : 16'h0000;
    end

endmodule // pdc_diag_regs

// ==== dv/pdc_alink_model.sv ====
module pdc_alink_model
(
    // Clock
    input  wire        clock,
    // Test engine handshake
    input  wire        alink_start,
    output logic       alink_done,
    output logic [7:0] alink_sum
);
    timeunit 1ns;
    timeprecision 1ns;
    parameter logic [7:0] SUM = 8'ha5;
    initial alink_done = 1'b0;
    // The sum is only meaningful while done is high, so it is scrambled otherwise.
    assign alink_sum = alink_done ? SUM : ~SUM;
    always @(posedge clock)
    begin
        if (alink_start)
        begin
            alink_done <= 1'b0;
            repeat (5) @(posedge clock);
            alink_done <= 1'b1;
        end
    end
endmodule // pdc_alink_model

// ==== dv/pdc_diag_regs_asserts.sv ====
`include "pdc_regs.vh"

module pdc_diag_regs_asserts
(
    // Clock and reset
    input wire        clock,
    input wire        arst_n,
    input wire        clk_en,
    // Register port
    input wire [11:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    // Outputs watched, with the retrain request
    input wire        dsp_gain_retrain_req,
    input wire        dsp_gain_retrain,
    input wire [2:0]  dsp_state_timer,
    input wire [5:0]  dsp_timing_timer,
    input wire [2:0]  dsp_gain_timer_a,
    input wire [2:0]  dsp_gain_timer_b,
    input wire        alink_start,
    input wire        refl_cross_en,
    input wire        refl_tx_run,
    input wire        refl_rx_run,
    input wire [6:0]  refl_avg_cycles,
    input wire [3:0]  refl_pulse_level,
    input wire [7:0]  refl_listen_len
);
    wire wr = reg_wr & clk_en;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_pulse;
        alink_start ##1 !alink_start;
    endsequence
    start_pulse_a: assert property (alink_start |-> s_pulse)
        else $error("start pulse too long");
    start_cause_a: assert property (alink_start |->
        $past(wr && reg_addr == `PDC_IDX_ALINK_DIAG && reg_wdata[15]))
        else $error("start without write of one");
    refl_mode_a: assert property (wr && reg_addr == `PDC_IDX_REFL_CTRL |=>
        {refl_cross_en, refl_tx_run, refl_rx_run} == ~$past(reg_wdata[14:12]))
        else $error("reflectometry mode bits wrong");
    avg_count_a: assert property (wr && reg_addr == `PDC_IDX_REFL_CTRL &&
        reg_wdata[10:8] != 3'h7 |=> refl_avg_cycles == 7'h1 << $past(reg_wdata[10:8]))
        else $error("averaging count wrong");
    pulse_level_a: assert property (wr && reg_addr == `PDC_IDX_REFL_PULSE |=>
        refl_pulse_level == $past(reg_wdata[3:0]))
        else $error("pulse level wrong");
    listen_len_a: assert property (wr && reg_addr == `PDC_IDX_REFL_LISTEN |=>
        refl_listen_len == $past(reg_wdata[15:8]))
        else $error("listen length wrong");
    retrain_cause_a: assert property (dsp_gain_retrain && $past(clk_en) |->
        $past(dsp_gain_retrain_req))
        else $error("retrain without request");
    train_timers_a: assert property (wr && reg_addr == `PDC_IDX_TRAIN_TMR |=>
        {dsp_state_timer, dsp_timing_timer, dsp_gain_timer_a, dsp_gain_timer_b}
        == $past(reg_wdata[14:0]))
        else $error("training timers wrong");
endmodule // pdc_diag_regs_asserts

bind pdc_diag_regs pdc_diag_regs_asserts pdc_diag_regs_asserts_i (.clock, .arst_n,
    .clk_en, .reg_addr, .reg_wdata, .reg_wr, .dsp_gain_retrain_req, .dsp_gain_retrain,
    .dsp_state_timer, .dsp_timing_timer, .dsp_gain_timer_a, .dsp_gain_timer_b,
    .alink_start, .refl_cross_en, .refl_tx_run, .refl_rx_run, .refl_avg_cycles,
    .refl_pulse_level, .refl_listen_len);

// ==== dv/pdc_diag_regs_tb.sv ====
`include "pdc_regs.vh"

module pdc_diag_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        dsp_mse_valid = 1'b0;
    logic [14:0] dsp_mse = 15'h0000;
    logic        dsp_gain_retrain_req = 1'b0;
    logic [3:0]  dsp_gain_req = 4'h0;
    wire  [15:0] reg_rdata;
    wire  [3:0]  dsp_gain_index, refl_pulse_level;
    wire  [7:0]  alink_sum, refl_listen_len;
    wire  [6:0]  refl_avg_cycles;
    wire         dsp_recovery, dsp_timing_locked, dsp_linkup_ok, dsp_gain_retrain;
    wire         alink_start, alink_done, refl_cross_en, refl_tx_run, refl_rx_run, irq;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [27:0] rows [15] = '{28'h116014a, 28'h121199a, 28'h1221027, 28'h123051c,
        28'h126461b, 28'h129000f, 28'h1300001, 28'h1550001, 28'h1700e52, 28'h171c85c,
        28'h173ff1e, 28'h177189b, 28'h1f00000, 28'h1f10000, 28'h1000000};

    always #25 clock = ~clock;

    pdc_diag_regs pdc_diag_regs_i (.clock, .arst_n, .clk_en(1'b1), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .dsp_mse_valid, .dsp_mse, .dsp_gain_retrain_req,
        .dsp_gain_req, .dsp_recovery, .dsp_timing_locked, .dsp_linkup_ok,
        .dsp_gain_retrain, .dsp_gain_index, .dsp_state_timer(), .dsp_timing_timer(),
        .dsp_gain_timer_a(), .dsp_gain_timer_b(), .alink_start, .alink_done, .alink_sum,
        .refl_cross_en, .refl_tx_run, .refl_rx_run, .refl_avg_cycles, .refl_pulse_level,
        .refl_listen_len, .irq);
    pdc_alink_model pdc_alink_model_i (.clock, .alink_start, .alink_done, .alink_sum);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic mse(input logic [14:0] v, input logic [2:0] exp);
        @(posedge clock);
        dsp_mse_valid <= 1'b1;
        dsp_mse <= v;
        @(posedge clock);
        dsp_mse_valid <= 1'b0;
        #1;
        chk({13'h0, dsp_recovery, dsp_timing_locked, dsp_linkup_ok}, {13'h0, exp});
    endtask
    task automatic gain(input logic [3:0] r, input logic [3:0] exp);
        @(posedge clock);
        dsp_gain_req <= r;
        repeat (2) @(posedge clock);
        #1;
        chk({12'h0, dsp_gain_index}, {12'h0, exp});
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        foreach (rows[i])
            rd(rows[i][27:16], rows[i][15:0]);
        chk({5'h0, refl_avg_cycles, refl_pulse_level}, 16'h040c);
        chk({8'h0, refl_listen_len}, 16'h00ff);
        chk({13'h0, refl_cross_en, refl_tx_run, refl_rx_run}, 16'h0007);
        $display("reset test done");
        // Mode bits follow the code so every bypass combination is visited.
        for (int c = 0; c < 8; c++)
        begin
            wr(`PDC_IDX_REFL_CTRL, {1'b0, 3'(c), 1'b1, 3'(c), 8'h52});
            chk({9'h0, refl_avg_cycles}, 16'h1 << (c == 7 ? 6 : c));
            chk({13'h0, refl_cross_en, refl_tx_run, refl_rx_run}, {13'h0, ~3'(c)});
        end
        rd(`PDC_IDX_REFL_CTRL, 16'h7f52);
        wr(`PDC_IDX_REFL_PULSE, 16'hc853);
        wr(`PDC_IDX_REFL_LISTEN, 16'h401e);
        chk({4'h0, refl_pulse_level, refl_listen_len}, 16'h0340);
        wr(`PDC_IDX_TRAIN_TMR, 16'h2bcd);
        rd(`PDC_IDX_TRAIN_TMR, 16'h2bcd);
        $display("reflectometry test done");
        wr(`PDC_IDX_BAD_THR, 16'hffff);
        rd(`PDC_IDX_BAD_THR, 16'h7fff);
        wr(`PDC_IDX_BAD_THR, 16'h0100);
        mse(15'h0100, 3'b011);
        mse(15'h051b, 3'b111);
        mse(15'h051c, 3'b110);
        mse(15'h1027, 3'b100);
        @(posedge clock);
        dsp_gain_retrain_req <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({15'h0, dsp_gain_retrain}, 16'h0001);
        wr(`PDC_IDX_GAIN_RETRAIN, 16'h0801);
        @(posedge clock);
        #1;
        chk({15'h0, dsp_gain_retrain}, 16'h0000);
        gain(4'h7, 4'h0);
        wr(`PDC_IDX_GAIN_LIM, 16'h00a3);
        gain(4'h1, 4'h3);
        gain(4'h5, 4'h5);
        gain(4'hf, 4'ha);
        $display("dsp test done");
        wr(`PDC_IDX_IRQ_STATUS, 16'h0007);
        wr(`PDC_IDX_IRQ_MASK, 16'h0001);
        wr(`PDC_IDX_ALINK_DIAG, 16'h0001);
        chk({15'h0, alink_start}, 16'h0000);
        wr(`PDC_IDX_ALINK_DIAG, 16'h8001);
        chk({15'h0, alink_start}, 16'h0001);
        wr(`PDC_IDX_ALINK_DIAG, 16'h8001);
        chk({15'h0, alink_start}, 16'h0000);
        rd(`PDC_IDX_ALINK_DIAG, 16'h1001);
        for (int k = 0; k < 40 && irq !== 1'b1; k++)
            @(posedge clock);
        #1;
        chk({15'h0, irq}, 16'h0001);
        rd(`PDC_IDX_ALINK_DIAG, 16'h0a51);
        wr(`PDC_IDX_IRQ_MASK, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        wr(`PDC_IDX_IRQ_MASK, 16'h0001);
        wr(`PDC_IDX_IRQ_STATUS, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        $display("active link test done");
        end_of_test();
    end

    initial
    begin
        #200us;
        n_fail++;
        end_of_test();
    end
endmodule // pdc_diag_regs_tb
